// File: design/pcs_core.sv
// Purpose: Program counter, return stack, indirect addressing and program-memory read port
// Assumes: Execution logic and software both reach the block over APB; one APB cycle is
//   one instruction cycle for the read sequence
// Notes: Program memory is an external array answering in the same cycle
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "pcs_regs.svh"
// Summary of operation
// - Thirteen-bit program counter; low byte readable and writable.
// - Upper counter bits readable only through the full-counter register; low-byte write loads them from latch bits 4..0.
// - Reset clears the upper program counter bits.
// - Call and jump use 11-bit target plus latch bits 4..3.
// - Eight-deep 13-bit return stack; its pointer is not visible.
// - Call pushes the counter plus one, interrupt vector pushes the counter; returns pop it.
// - Push and pop never touch the upper-address latch.
// - Stack wraps; the ninth push overwrites the first entry.
// - No overflow or underflow indication exists.
// - Indirect port reaches file address bank bit joined with pointer.
// - Indirect read with pointer zero returns 00h.
// - Indirect write through itself changes no register.
// - Invalid instruction words execute as no-operation.
// - Read port takes 13-bit address, returns 14-bit word.
// - Unused upper bits of data-high and address-high read zero.
// - Read trigger is set-only by software, cleared by hardware at completion.
// - Read takes two cycles; second following instruction ignored.
// - Data registers keep the last word until the next read.
// - Control bit 7 reads one, bits 6..1 read zero.
module pcs_core
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [12:0] pmem_addr,
  input wire logic [13:0] pmem_rdata,
  output logic [8:0] file_addr,
  output logic file_we,
  output logic [7:0] file_wdata,
  input wire logic [7:0] file_rdata,
  output logic instr_ignore
);
  logic [12:0] pc_q, pc_d;
  logic [7:0] latch_q, latch_d;
  logic [12:0] stack_q [0:`PCS_STACK_DEPTH-1];
  logic [12:0] stack_d [0:`PCS_STACK_DEPTH-1];
  logic [2:0] sp_q, sp_d;
  logic [7:0] ptr_q, ptr_d;
  logic bank_q, bank_d;
  logic [7:0] adr_lo_q, adr_lo_d;
  logic [4:0] adr_hi_q, adr_hi_d;
  logic [7:0] dat_lo_q, dat_lo_d;
  logic [5:0] dat_hi_q, dat_hi_d;
  pcs_pkg::pcs_rd_e rd_q, rd_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [8:0] fa_q, fa_d;
  logic fwe_q, fwe_d;
  logic [7:0] fwd_q, fwd_d;
  logic ign_q, ign_d;
  logic [12:0] pma_q, pma_d;

  function automatic logic is_idx(input logic [31:0] a, input logic [11:0] idx);
    is_idx = (a[1:0] == 2'b00) && (a[31:14] == 18'h0_0000) && (a[13:2] == idx);
  endfunction

  // Page jumps keep the latch page; a far target needs the latch set first
  function automatic logic [12:0] page_target(input logic [7:0] lat, input logic [31:0] wd);
    page_target = {lat[4:3], wd[10:0]};
  endfunction

  // Step wraps at the top of the 8K word space
  function automatic logic [12:0] pc_inc(input logic [12:0] pc);
    pc_inc = pc + 13'h0001;
  endfunction

  // Three-bit pointer wraps by itself, so the stack is circular
  function automatic logic [2:0] sp_push(input logic [2:0] sp);
    sp_push = sp + 3'd1;
  endfunction

  function automatic logic [2:0] sp_pop(input logic [2:0] sp);
    sp_pop = sp - 3'd1;
  endfunction

  logic access;
  logic wr;
  logic [7:0] wb;
  assign access = psel && penable && !pready_q;
  assign wr = access && pwrite;
  assign wb = pwdata[7:0];

  logic cmd_wr;
  logic [2:0] cmd_code;
  assign cmd_wr = wr && is_idx(paddr, `PCS_IDX_CORE_CMD);
  assign cmd_code = pwdata[18:16];

  // Stack group; the pointer is never exposed and wraps with no flag
  // Popping an empty stack simply wraps and returns stale data
  always_comb
  begin
    stack_d = stack_q;
    sp_d = sp_q;
    if (cmd_wr)
    begin
      case (cmd_code)
        pcs_pkg::PCS_CMD_CALL:
        begin
          stack_d[sp_q] = pc_inc(pc_q);
          sp_d = sp_push(sp_q);
        end
        pcs_pkg::PCS_CMD_INTVEC:
        begin
          stack_d[sp_q] = pc_q;
          sp_d = sp_push(sp_q);
        end
        pcs_pkg::PCS_CMD_RETURN:
        begin
          sp_d = sp_pop(sp_q);
        end
        default:
        begin
          sp_d = sp_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < `PCS_STACK_DEPTH; i++)
      begin
        stack_q[i] <= 13'h0000;
      end
      sp_q <= 3'd0;
    end
    else
    begin
      stack_q <= stack_d;
      sp_q <= sp_d;
    end
  end

  always_comb
  begin
    pc_d = pc_q;
    latch_d = latch_q;
    ptr_d = ptr_q;
    bank_d = bank_q;
    adr_lo_d = adr_lo_q;
    adr_hi_d = adr_hi_q;
    dat_lo_d = dat_lo_q;
    dat_hi_d = dat_hi_q;
    rd_d = rd_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    fa_d = fa_q;
    fwe_d = 1'b0;
    fwd_d = fwd_q;
    ign_d = 1'b0;
    pma_d = pma_q;
    // Read sequence advances once per instruction cycle, here once per APB access
    if (access)
    begin
      case (rd_q)
        pcs_pkg::PCS_RD_CYC1:
        begin
          rd_d = pcs_pkg::PCS_RD_CYC2;
        end
        pcs_pkg::PCS_RD_CYC2:
        begin
          dat_lo_d = pmem_rdata[7:0];
          dat_hi_d = pmem_rdata[13:8];
          rd_d = pcs_pkg::PCS_RD_IDLE;
          ign_d = 1'b1;
        end
        default:
        begin
          rd_d = pcs_pkg::PCS_RD_IDLE;
        end
      endcase
    end
    if (access)
    begin
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      if (is_idx(paddr, `PCS_IDX_PC_LOW))
      begin
        prdata_d = {24'h00_0000, pc_q[7:0]};
        if (wr)
        begin
          // Upper bits always from latch, so no carry out of the low byte
          pc_d = {latch_q[4:0], wb};
        end
      end
      else if (is_idx(paddr, `PCS_IDX_PC_LATCH))
      begin
        prdata_d = {24'h00_0000, latch_q};
        if (wr)
        begin
          latch_d = wb;
        end
      end
      else if (is_idx(paddr, `PCS_IDX_IND_PTR))
      begin
        prdata_d = {24'h00_0000, ptr_q};
        if (wr)
        begin
          ptr_d = wb;
        end
      end
      else if (is_idx(paddr, `PCS_IDX_STATUS))
      begin
        prdata_d = {24'h00_0000, bank_q, 7'h00};
        if (wr)
        begin
          bank_d = wb[`PCS_BANK_BIT];
        end
      end
      else if (is_idx(paddr, `PCS_IDX_IND_PORT))
      begin
        fa_d = {bank_q, ptr_q};
        if (ptr_q == 8'h00)
        begin
          prdata_d = 32'h0000_0000;
        end
        else if (wr)
        begin
          fwe_d = 1'b1;
          fwd_d = wb;
        end
      end
      else if (is_idx(paddr, `PCS_IDX_FILE_DATA))
      begin
        prdata_d = {24'h00_0000, file_rdata};
      end
      else if (is_idx(paddr, `PCS_IDX_RD_CTRL))
      begin
        prdata_d = {24'h00_0000, `PCS_RD_CTRL_RSV | {7'h00, rd_q != pcs_pkg::PCS_RD_IDLE}};
        if (wr && wb[`PCS_RD_BIT] && rd_q == pcs_pkg::PCS_RD_IDLE)
        begin
          // Writing zero is ignored: the trigger cannot be cleared by software
          rd_d = pcs_pkg::PCS_RD_CYC1;
          pma_d = {adr_hi_q, adr_lo_q};
        end
      end
      else if (is_idx(paddr, `PCS_IDX_ADDR_LOW))
      begin
        prdata_d = {24'h00_0000, adr_lo_q};
        if (wr)
        begin
          adr_lo_d = wb;
        end
      end
      else if (is_idx(paddr, `PCS_IDX_ADDR_HIGH))
      begin
        prdata_d = {27'h000_0000, adr_hi_q};
        if (wr)
        begin
          adr_hi_d = wb[4:0];
        end
      end
      else if (is_idx(paddr, `PCS_IDX_DATA_LOW))
      begin
        prdata_d = {24'h00_0000, dat_lo_q};
      end
      else if (is_idx(paddr, `PCS_IDX_DATA_HIGH))
      begin
        prdata_d = {26'h000_0000, dat_hi_q};
      end
      else if (is_idx(paddr, `PCS_IDX_PC_FULL))
      begin
        prdata_d = {19'h0_0000, pc_q};
      end
      else if (is_idx(paddr, `PCS_IDX_CORE_CMD))
      begin
        // Stack pointer is never exposed; no flag on wrap either way
        if (wr)
        begin
          case (pwdata[18:16])
            pcs_pkg::PCS_CMD_STEP:
            begin
              pc_d = pc_inc(pc_q);
            end
            pcs_pkg::PCS_CMD_GOTO:
            begin
              pc_d = page_target(latch_q, pwdata);
            end
            pcs_pkg::PCS_CMD_CALL:
            begin
              pc_d = page_target(latch_q, pwdata);
            end
            pcs_pkg::PCS_CMD_RETURN:
            begin
              pc_d = stack_q[sp_pop(sp_q)];
            end
            pcs_pkg::PCS_CMD_INTVEC:
            begin
              pc_d = pwdata[12:0];
            end
            default:
            begin
              // Unknown encodings behave as a no-operation step
              pc_d = pc_inc(pc_q);
            end
          endcase
        end
      end
      else
      begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pc_q <= 13'h0000;
      latch_q <= 8'h00;
      ptr_q <= 8'h00;
      bank_q <= 1'b0;
      adr_lo_q <= 8'h00;
      adr_hi_q <= 5'h00;
      dat_lo_q <= 8'h00;
      dat_hi_q <= 6'h00;
      rd_q <= pcs_pkg::PCS_RD_IDLE;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      fa_q <= 9'h000;
      fwe_q <= 1'b0;
      fwd_q <= 8'h00;
      ign_q <= 1'b0;
      pma_q <= 13'h0000;
    end
    else
    begin
      pc_q <= pc_d;
      latch_q <= latch_d;
      ptr_q <= ptr_d;
      bank_q <= bank_d;
      adr_lo_q <= adr_lo_d;
      adr_hi_q <= adr_hi_d;
      dat_lo_q <= dat_lo_d;
      dat_hi_q <= dat_hi_d;
      rd_q <= rd_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      fa_q <= fa_d;
      fwe_q <= fwe_d;
      fwd_q <= fwd_d;
      ign_q <= ign_d;
      pma_q <= pma_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pmem_addr = pma_q;
  assign file_addr = fa_q;
  assign file_we = fwe_q;
  assign file_wdata = fwd_q;
  assign instr_ignore = ign_q;
endmodule

// File: design/pcs_pkg.sv
// Purpose: Types for the program-flow block
// Assumes: Used with pcs_regs.svh
// Notes: Commands arrive from the execution logic as register writes
package pcs_pkg;
  typedef logic [12:0] pcs_addr_t;
  typedef logic [13:0] pcs_word_t;
  typedef enum logic [2:0]
  {
    PCS_CMD_STEP,
    PCS_CMD_GOTO,
    PCS_CMD_CALL,
    PCS_CMD_RETURN,
    PCS_CMD_INTVEC,
    PCS_CMD_EXEC
  } pcs_cmd_e;
  typedef enum logic [1:0]
  {
    PCS_RD_IDLE,
    PCS_RD_CYC1,
    PCS_RD_CYC2
  } pcs_rd_e;
endpackage

// File: design/pcs_regs.svh
// Purpose: Register offsets, field positions and reset values for the program-flow block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Printed offsets are not all multiples of four, so each is an index; byte address is 4x
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH
`define PCS_IDX_PC_LOW 12'h002
`define PCS_IDX_PC_LATCH 12'h00a
`define PCS_IDX_IND_PORT 12'h000
`define PCS_IDX_IND_PTR 12'h004
`define PCS_IDX_STATUS 12'h003
`define PCS_IDX_RD_CTRL 12'h10c
`define PCS_IDX_DATA_LOW 12'h18c
`define PCS_IDX_ADDR_LOW 12'h18d
`define PCS_IDX_DATA_HIGH 12'h18e
`define PCS_IDX_ADDR_HIGH 12'h18f
`define PCS_IDX_CORE_CMD 12'h040
`define PCS_IDX_CORE_TGT 12'h041
`define PCS_IDX_PC_FULL 12'h042
`define PCS_IDX_FILE_DATA 12'h043
`define PCS_RD_BIT 0
`define PCS_RD_RSVD_BIT 7
`define PCS_BANK_BIT 7
`define PCS_RD_CTRL_RSV 8'h80
`define PCS_STACK_DEPTH 8
`define PCS_RD_CYCLES 2
`endif

// File: tb/pcs_core_sva.sv
// Purpose: Port-level assertions for pcs_core
// Assumes: One wait state per APB access
// Notes: Bound into every pcs_core instance
`timescale 1ns/1ps
`include "pcs_regs.svh"
module pcs_core_sva
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [12:0] pmem_addr,
  input wire logic [13:0] pmem_rdata,
  input wire logic [8:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] file_rdata,
  input wire logic instr_ignore
);
  localparam logic [31:0] A_C = {18'h0, `PCS_IDX_RD_CTRL, 2'b00};
  localparam logic [31:0] A_DH = {18'h0, `PCS_IDX_DATA_HIGH, 2'b00};
  localparam logic [31:0] A_AH = {18'h0, `PCS_IDX_ADDR_HIGH, 2'b00};
  localparam logic [31:0] A_IP = {18'h0, `PCS_IDX_IND_PORT, 2'b00};
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("no pready");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  chk_ctrl_fixed: assert property (pready && !pwrite && paddr == A_C
    |-> prdata[31:1] == 31'h0000_0040) else $error("control read bad");
  chk_dhigh_zero: assert property (pready && !pwrite && paddr == A_DH
    |-> prdata[31:6] == 26'h0) else $error("data high bits");
  chk_ahigh_zero: assert property (pready && !pwrite && paddr == A_AH
    |-> prdata[31:5] == 27'h0) else $error("addr high bits");
  chk_pm_launch: assert property (!$stable(pmem_addr)
    |-> pready && pwrite && paddr == A_C) else $error("pmem_addr moved");
  chk_ignore_pulse: assert property (instr_ignore |=> !instr_ignore) else $error("ignore long");
  chk_ignore_after: assert property (instr_ignore |-> pready) else $error("ignore early");
  chk_we_nonzero: assert property (file_we |-> file_addr[7:0] != 8'h00) else $error("self write");
  chk_ind_zero: assert property (pready && !pwrite && paddr == A_IP
    |-> prdata == 32'h0000_0000) else $error("indirect read");
  cover property (instr_ignore);
  cover property (file_we);
  cover property (pslverr);
endmodule
bind pcs_core pcs_core_sva u_sva (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
  .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
  .file_rdata(file_rdata), .instr_ignore(instr_ignore));

// File: tb/pcs_mem_model.sv
// Purpose: Program memory and file register array beside pcs_core
// Assumes: Both answer combinationally for the presented address
// Notes: Word pattern is a fixed function of address so reads can be predicted
`timescale 1ns/1ps
module pcs_mem_model
(
  input wire logic clk,
  input wire logic [12:0] pmem_addr,
  output logic [13:0] pmem_rdata,
  input wire logic [8:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] ram [512];
  initial
  begin
    foreach (ram[i]) ram[i] = 8'h00;
  end
  assign pmem_rdata = {~pmem_addr[0], pmem_addr} ^ 14'h2a5c;
  assign file_rdata = ram[file_addr];
  always_ff @(posedge clk)
  begin
    if (file_we)
      ram[file_addr] <= file_wdata;
  end
endmodule

// File: tb/program_counter_stack_and_progmem_read_bench.sv
// Purpose: Self-checking bench for pcs_core
// Assumes: APB master waits for pready; memory model beside the core
// Notes: Random values from a fixed seed
`timescale 1ns/1ps
`include "pcs_regs.svh"
module program_counter_stack_and_progmem_read_bench;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, file_we, instr_ignore, er;
  logic [12:0] pmem_addr, a, v, pc;
  logic [12:0] stk [8];
  logic [13:0] pmem_rdata, w;
  logic [8:0] file_addr;
  logic [7:0] file_wdata, file_rdata, b, p, d;
  logic [4:0] lat;
  logic [2:0] cmd;
  int n_mismatch = 0, n_tests = 0, sp;
  integer seed = 32'hf7024436;
  always #20 clk = ~clk;
  pcs_core DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
    .file_rdata(file_rdata), .instr_ignore(instr_ignore));
  pcs_mem_model u_mem (.clk(clk), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
    .file_rdata(file_rdata));
  function automatic logic [13:0] pmw(input logic [12:0] x);
    return {~x[0], x} ^ 14'h2a5c;
  endfunction
  task automatic print_verdict;
    $display("Counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr_en;
    paddr <= {18'h0, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 20)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
    apb(1, idx, wd);
  endtask
  task automatic rdx(input logic [11:0] idx, input logic [31:0] exp);
    apb(0, idx, 0);
    chk(rd, exp);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1;
    rdx(`PCS_IDX_RD_CTRL, 32'h0000_0080);
    rdx(`PCS_IDX_PC_FULL, 0);
    for (int i = 0; i < 5; i++)
    begin
      a = (i == 4) ? 13'h1fff : 13'($random(seed));
      wr(`PCS_IDX_ADDR_HIGH, {27'h0, a[12:8]});
      wr(`PCS_IDX_ADDR_LOW, {24'h0, a[7:0]});
      if (i > 0)
        rdx(`PCS_IDX_DATA_LOW, {24'h0, w[7:0]});
      wr(`PCS_IDX_RD_CTRL, 1);
      chk({19'h0, pmem_addr}, {19'h0, a});
      rdx(`PCS_IDX_RD_CTRL, 32'h0000_0081);
      wr(`PCS_IDX_RD_CTRL, 0);
      chk({31'h0, instr_ignore}, 1);
      w = pmw(a);
      rdx(`PCS_IDX_RD_CTRL, 32'h0000_0080);
      rdx(`PCS_IDX_DATA_LOW, {24'h0, w[7:0]});
      rdx(`PCS_IDX_DATA_HIGH, {26'h0, w[13:8]});
      rdx(`PCS_IDX_ADDR_HIGH, {27'h0, a[12:8]});
    end
    $display("program memory reads done");
    lat = 5'($random(seed));
    b = 8'($random(seed));
    wr(`PCS_IDX_PC_LATCH, {27'h0, lat});
    wr(`PCS_IDX_PC_LOW, {24'h0, b});
    pc = {lat, b};
    rdx(`PCS_IDX_PC_FULL, {19'h0, pc});
    rdx(`PCS_IDX_PC_LOW, {24'h0, b});
    for (int c = 1; c < 9; c++)
    begin
      v = 13'($random(seed));
      cmd = (c == 8) ? 3'd0 : 3'(c);
      if (cmd != 3'd2 && cmd != 3'd3 && cmd != 3'd4)
      begin
        wr(`PCS_IDX_CORE_CMD, {13'h0, cmd, 3'h0, v});
        pc = (cmd == 3'd1) ? {lat[4:3], v[10:0]} : pc + 13'h1;
        rdx(`PCS_IDX_PC_FULL, {19'h0, pc});
      end
    end
    sp = 0;
    for (int i = 0; i < 10; i++)
    begin
      v = 13'($random(seed));
      cmd = (i == 3) ? 3'd4 : 3'd2;
      wr(`PCS_IDX_CORE_CMD, {13'h0, cmd, 3'h0, v});
      stk[sp] = (i == 3) ? pc : pc + 13'h1;
      pc = (i == 3) ? v : {lat[4:3], v[10:0]};
      sp = (sp + 1) % 8;
      rdx(`PCS_IDX_PC_FULL, {19'h0, pc});
    end
    for (int i = 0; i < 10; i++)
    begin
      wr(`PCS_IDX_CORE_CMD, 32'h0003_0000);
      sp = (sp + 7) % 8;
      pc = stk[sp];
      rdx(`PCS_IDX_PC_FULL, {19'h0, pc});
    end
    rdx(`PCS_IDX_PC_LATCH, {27'h0, lat});
    $display("program counter and stack done");
    p = 8'($random(seed)) | 8'h01;
    d = 8'($random(seed));
    wr(`PCS_IDX_STATUS, 32'h0000_0080);
    wr(`PCS_IDX_IND_PTR, {24'h0, p});
    wr(`PCS_IDX_IND_PORT, {24'h0, d});
    chk({23'h0, file_addr}, {23'h0, 1'b1, p});
    chk({31'h0, file_we}, 1);
    chk({24'h0, file_wdata}, {24'h0, d});
    rdx(`PCS_IDX_FILE_DATA, {24'h0, d});
    wr(`PCS_IDX_IND_PTR, 0);
    wr(`PCS_IDX_IND_PORT, 32'h0000_005a);
    chk({31'h0, file_we}, 0);
    rdx(`PCS_IDX_IND_PORT, 0);
    rdx(`PCS_IDX_FILE_DATA, 0);
    $display("indirect addressing done");
    apb(0, `PCS_IDX_CORE_TGT, 0);
    chk({31'h0, er}, 1);
    chk(rd, 0);
    reset_n <= 0;
    repeat (8) @(posedge clk);
    reset_n <= 1;
    rdx(`PCS_IDX_PC_FULL, 0);
    $display("unmapped and reset done");
    print_verdict();
  end
endmodule
